// ### pmsc_params.svh
// Constants for the mask and system-control register slice.
// Assumes a 100 MHz system clock and 9-bit register addresses.
`ifndef PMSC_PARAMS_SVH
`define PMSC_PARAMS_SVH

// Register addresses
`define PMSC_ADDR_MASK_A 9'h00A
`define PMSC_ADDR_MASK_B 9'h00B
`define PMSC_ADDR_MASK_C 9'h00C
`define PMSC_ADDR_CTRL_A 9'h00E
`define PMSC_ADDR_CTRL_B 9'h00F
`define PMSC_ADDR_CTRL_C 9'h010
`define PMSC_ADDR_CTRL_D 9'h011
`define PMSC_ADDR_CTRL_E 9'h012
// Write-lock window and its single hole
`define PMSC_LOCK_LO 9'h081
`define PMSC_LOCK_HI 9'h120
`define PMSC_LOCK_HOLE 9'h100

// Writable bits of each register except supply_boot_debounce_config, which takes all bits; reserved bits read zero
`define PMSC_MASK_A_BITS 8'h19
`define PMSC_MASK_B_BITS 8'hAA
`define PMSC_MASK_C_BITS 8'h1F
`define PMSC_CTRL_A_BITS 8'h7F
`define PMSC_CTRL_B_BITS 8'hFE
`define PMSC_CTRL_D_BITS 8'h07
`define PMSC_CTRL_E_BITS 8'h80
`define PMSC_RESET_VAL 8'h00

// Field positions
`define PMSC_A_SYS_DOMAIN_REQUEST_IN 0
`define PMSC_A_PWR_EN 1
`define PMSC_A_PWR1_EN 2
`define PMSC_A_STANDBY 3
`define PMSC_A_GATE_OFS 4
`define PMSC_B_WDT_SLEEP 1
`define PMSC_B_FREEZE_EN 2
`define PMSC_B_RES_MODE 3
`define PMSC_B_KEY_LOCK 4
`define PMSC_B_LIMIT_LSB 5
`define PMSC_B_SLOWSTART 7
`define PMSC_C_DEB_LSB 0
`define PMSC_C_AUTO_BOOT 3
`define PMSC_C_OTP_WAKE 4
`define PMSC_C_SLEW_LSB 5
`define PMSC_C_SLOT0_DEFAULT_SUPPLIES 7
`define PMSC_E_LOCK 7

// Timing: clock rate, base tick, debounce table in ticks
`define PMSC_CLK_MHZ 100
`define PMSC_TICK_US 10
`define PMSC_TICK_CYCLES (`PMSC_TICK_US * `PMSC_CLK_MHZ)
`define PMSC_DEB_0_1MS 17'd10
`define PMSC_DEB_1MS 17'd100
`define PMSC_DEB_10_24MS 17'd1024
`define PMSC_DEB_51_2MS 17'd5120
`define PMSC_DEB_256MS 17'd25600
`define PMSC_DEB_512MS 17'd51200
`define PMSC_DEB_1024MS 17'd102400
// Watchdog base 2.048 s expressed in 10 us ticks
`define PMSC_WDT_BASE_MS 2048
`define PMSC_WDT_BASE_TICKS (`PMSC_WDT_BASE_MS * 1000 / `PMSC_TICK_US)
// Ramp step interval for buck 1 and 3 at code 00, in ns
`define PMSC_RAMP_BASE_NS 4000
`define PMSC_CLK_NS (1000 / `PMSC_CLK_MHZ)
`define PMSC_DEB_INPUTS 7

`endif

// ### pmsc_pkg.sv
// Types shared by the mask and system-control register slice.
// Assumes nothing beyond the constants header.
package pmsc_pkg;

  // Latched event flags supplied by the neighbouring event registers
  typedef struct packed {
    logic [7:0] grp_a;
    logic [7:0] grp_b;
    logic [7:0] grp_c;
  } pmsc_flags_s;

  // Register-port request from the two-wire interface engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } pmsc_req_s;

endpackage

// ### pmsc_debounce.sv
// Two-flop synchroniser and tick-counted debouncer for one pin.
// Assumes tick is a one-cycle pulse from clk_sys logic.
`timescale 1ns/1ps
`default_nettype none
module pmsc_debounce (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic raw_in,
  input wire logic tick,
  input wire logic [16:0] limit,
  output logic clean
);
  logic sync1, sync2;
  logic [16:0] cnt, next_cnt;
  logic next_clean;

  // Count ticks of stable disagreement; a glitch restarts the wait
  always_comb begin
    next_cnt = cnt;
    next_clean = clean;
    if (limit == 17'h00000) begin
      next_clean = sync2;
      next_cnt = 17'h00000;
    end else if (sync2 == clean) begin
      next_cnt = 17'h00000;
    end else if (tick) begin
      if (cnt + 17'h00001 >= limit) begin
        next_clean = sync2;
        next_cnt = 17'h00000;
      end else begin
        next_cnt = cnt + 17'h00001;
      end
    end
  end

  // Pin is asynchronous, so two flops before anything reads it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      cnt <= 17'h00000;
      clean <= 1'b0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      cnt <= next_cnt;
      clean <= next_clean;
    end
  end
endmodule
`default_nettype wire

// ### pmsc_regs.sv
// Interrupt-mask and system-control register slice of the power manager.
// Assumes the two-wire engine presents one-cycle wr/rd strobes on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "pmsc_params.svh"
module pmsc_regs
  import pmsc_pkg::*;
#(
  parameter int TICK_CYCLES = `PMSC_TICK_CYCLES,
  parameter int WDT_BASE_TICKS = `PMSC_WDT_BASE_TICKS
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire pmsc_req_s req,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  output logic write_locked,
  input wire pmsc_flags_s flags,
  output logic [1:0] event_summary,
  output logic irq_n,
  input wire logic sys_domain_request_in,
  input wire logic power_key_long_press,
  output logic low_power_state_request,
  output logic low_power_state_to_partial,
  output logic [2:0] domain_targets,
  input wire logic low_power_state,
  output logic system_reset_out_n,
  output logic soft_inrush_enable,
  output logic key_lock_low_power_state_select,
  output logic wake_blocked,
  output logic slot0_default_supplies,
  output logic wake_config_reload_enable,
  output logic auto_boot,
  output logic [9:0] ramp_step_cycles_b13,
  output logic [9:0] ramp_step_cycles_b2,
  input wire logic [4:0] gpi_raw,
  input wire logic power_key_n,
  input wire logic reset_request_in_n,
  output logic [`PMSC_DEB_INPUTS-1:0] debounced,
  input wire logic wdt_kick,
  output logic wdt_timeout
);
  logic [7:0] irq_mask_group_a, irq_mask_group_b, irq_mask_group_c;
  logic [7:0] power_domain_targets, power_behaviour_options;
  logic [7:0] supply_boot_debounce_config, wdt_timeout_scale;
  logic [7:0] register_write_lock;
  logic [7:0] next_mask_a, next_mask_b, next_mask_c, next_ctrl_a;
  logic [7:0] next_ctrl_b, next_ctrl_c, next_ctrl_d, next_ctrl_e;
  logic [7:0] next_rdata;
  logic next_hit;
  logic sys_req_s1, sys_req_s2, sys_req_d;
  logic next_pd_req;
  logic [1:0] trials, next_trials;
  logic [15:0] tick_cnt, next_tick_cnt;
  logic tick;
  logic [23:0] wdt_cnt, next_wdt_cnt;
  logic next_wdt_timeout;
  logic wdt_run;
  logic [23:0] wdt_limit;
  logic [16:0] deb_limit;
  logic [`PMSC_DEB_INPUTS-1:0] deb_raw;
  logic wr_ok;
  logic [2:0] gate;
  logic [2:0] new_targets;

  // Address match used by the write decode; the read mux uses a case on the address
  function automatic logic hit(input logic [8:0] a, input logic [8:0] b);
    return a == b;
  endfunction

  // Ramp interval in clocks for a slew code, halved per code step
  function automatic logic [9:0] ramp_cycles(input logic [1:0] code,
                                             input logic dbl);
    int ns;
    ns = (`PMSC_RAMP_BASE_NS >> code) << dbl;
    return 10'(ns / `PMSC_CLK_NS);
  endfunction

  // Lock window check on every host write address
  always_comb begin
    write_locked = register_write_lock[`PMSC_E_LOCK] && req.wr &&
      req.addr >= `PMSC_LOCK_LO && req.addr <= `PMSC_LOCK_HI &&
      req.addr != `PMSC_LOCK_HOLE;
  end
  assign wr_ok = req.wr && !write_locked;

  // Domain targets: only bits whose gate is set take the new value
  assign gate = req.wdata[`PMSC_A_GATE_OFS +: 3];
  assign new_targets = (power_domain_targets[2:0] & ~gate) |
                       (req.wdata[2:0] & gate);

  // Register writes; reserved bits are held at zero
  always_comb begin
    next_mask_a = irq_mask_group_a;
    next_mask_b = irq_mask_group_b;
    next_mask_c = irq_mask_group_c;
    next_ctrl_a = power_domain_targets;
    next_ctrl_b = power_behaviour_options;
    next_ctrl_c = supply_boot_debounce_config;
    next_ctrl_d = wdt_timeout_scale;
    next_ctrl_e = register_write_lock;
    if (wr_ok) begin
      if (hit(req.addr, `PMSC_ADDR_MASK_A))
        next_mask_a = req.wdata & `PMSC_MASK_A_BITS;
      if (hit(req.addr, `PMSC_ADDR_MASK_B))
        next_mask_b = req.wdata & `PMSC_MASK_B_BITS;
      if (hit(req.addr, `PMSC_ADDR_MASK_C))
        next_mask_c = req.wdata & `PMSC_MASK_C_BITS;
      if (hit(req.addr, `PMSC_ADDR_CTRL_A))
        next_ctrl_a = {req.wdata[7:3], new_targets} &
                      `PMSC_CTRL_A_BITS;
      if (hit(req.addr, `PMSC_ADDR_CTRL_B))
        next_ctrl_b = req.wdata & `PMSC_CTRL_B_BITS;
      if (hit(req.addr, `PMSC_ADDR_CTRL_C))
        next_ctrl_c = req.wdata;
      if (hit(req.addr, `PMSC_ADDR_CTRL_D))
        next_ctrl_d = req.wdata & `PMSC_CTRL_D_BITS;
      if (hit(req.addr, `PMSC_ADDR_CTRL_E))
        next_ctrl_e = req.wdata & `PMSC_CTRL_E_BITS;
    end
  end

  // Read mux, registered so read data comes from a flop
  always_comb begin
    next_hit = 1'b1;
    case (req.addr)
      `PMSC_ADDR_MASK_A: next_rdata = irq_mask_group_a;
      `PMSC_ADDR_MASK_B: next_rdata = irq_mask_group_b;
      `PMSC_ADDR_MASK_C: next_rdata = irq_mask_group_c;
      `PMSC_ADDR_CTRL_A: next_rdata = power_domain_targets;
      `PMSC_ADDR_CTRL_B: next_rdata = power_behaviour_options;
      `PMSC_ADDR_CTRL_C: next_rdata = supply_boot_debounce_config;
      `PMSC_ADDR_CTRL_D: next_rdata = wdt_timeout_scale;
      `PMSC_ADDR_CTRL_E: next_rdata = register_write_lock;
      default: begin
        next_rdata = 8'h00;
        next_hit = 1'b0;
      end
    endcase
    if (!req.rd) begin
      next_rdata = reg_rdata;
      next_hit = 1'b0;
    end
  end

  // Power-down trigger: system target cleared, pin released, long press
  always_comb begin
    next_pd_req = power_key_long_press ||
      (sys_req_d && !sys_req_s2) ||
      (power_domain_targets[`PMSC_A_SYS_DOMAIN_REQUEST_IN] &&
       !next_ctrl_a[`PMSC_A_SYS_DOMAIN_REQUEST_IN]);
  end

  // Shared 10 us tick for debounce and watchdog keeps counters narrow
  always_comb begin
    tick = (tick_cnt == 16'(TICK_CYCLES - 1));
    next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
  end

  // Watchdog: scale 0 disables, sleep gating by option bit
  always_comb begin
    wdt_limit = 24'(WDT_BASE_TICKS) << (wdt_timeout_scale[2:0] - 3'h1);
    wdt_run = (wdt_timeout_scale[2:0] != 3'h0) &&
      (!low_power_state ||
       power_behaviour_options[`PMSC_B_WDT_SLEEP]);
    next_wdt_cnt = wdt_cnt;
    next_wdt_timeout = 1'b0;
    if (!wdt_run || wdt_kick) begin
      next_wdt_cnt = 24'h000000;
    end else if (tick) begin
      if (wdt_cnt + 24'h000001 >= wdt_limit) begin
        next_wdt_cnt = 24'h000000;
        next_wdt_timeout = 1'b1;
      end else begin
        next_wdt_cnt = wdt_cnt + 24'h000001;
      end
    end
  end

  // Restart trials: saturating count of watchdog expiries
  always_comb begin
    next_trials = trials;
    if (!power_behaviour_options[`PMSC_B_FREEZE_EN])
      next_trials = 2'h0;
    else if (wdt_timeout && trials != 2'h3)
      next_trials = trials + 2'h1;
  end

  // Debounce length lookup; the tick keeps the table under 17 bits
  always_comb begin
    case (supply_boot_debounce_config[`PMSC_C_DEB_LSB +: 3])
      3'h0: deb_limit = 17'h00000;
      3'h1: deb_limit = `PMSC_DEB_0_1MS;
      3'h2: deb_limit = `PMSC_DEB_1MS;
      3'h3: deb_limit = `PMSC_DEB_10_24MS;
      3'h4: deb_limit = `PMSC_DEB_51_2MS;
      3'h5: deb_limit = `PMSC_DEB_256MS;
      3'h6: deb_limit = `PMSC_DEB_512MS;
      default: deb_limit = `PMSC_DEB_1024MS;
    endcase
  end

  assign deb_raw = {reset_request_in_n, power_key_n, gpi_raw};

  // One debouncer per pin; each synchronises its own input
  for (genvar i = 0; i < `PMSC_DEB_INPUTS; i++) begin : g_deb
    pmsc_debounce u_deb (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .raw_in(deb_raw[i]),
      .tick(tick),
      .limit(deb_limit),
      .clean(debounced[i])
    );
  end

  // State registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_mask_group_a <= `PMSC_RESET_VAL;
      irq_mask_group_b <= `PMSC_RESET_VAL;
      irq_mask_group_c <= `PMSC_RESET_VAL;
      power_domain_targets <= `PMSC_RESET_VAL;
      power_behaviour_options <= `PMSC_RESET_VAL;
      supply_boot_debounce_config <= `PMSC_RESET_VAL;
      wdt_timeout_scale <= `PMSC_RESET_VAL;
      register_write_lock <= `PMSC_RESET_VAL;
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
      sys_req_s1 <= 1'b0;
      sys_req_s2 <= 1'b0;
      sys_req_d <= 1'b0;
      low_power_state_request <= 1'b0;
      trials <= 2'h0;
      tick_cnt <= 16'h0000;
      wdt_cnt <= 24'h000000;
      wdt_timeout <= 1'b0;
    end else begin
      irq_mask_group_a <= next_mask_a;
      irq_mask_group_b <= next_mask_b;
      irq_mask_group_c <= next_mask_c;
      power_domain_targets <= next_ctrl_a;
      power_behaviour_options <= next_ctrl_b;
      supply_boot_debounce_config <= next_ctrl_c;
      wdt_timeout_scale <= next_ctrl_d;
      register_write_lock <= next_ctrl_e;
      reg_rdata <= next_rdata;
      reg_hit <= next_hit;
      sys_req_s1 <= sys_domain_request_in;
      sys_req_s2 <= sys_req_s1;
      sys_req_d <= sys_req_s2;
      low_power_state_request <= next_pd_req;
      trials <= next_trials;
      tick_cnt <= next_tick_cnt;
      wdt_cnt <= next_wdt_cnt;
      wdt_timeout <= next_wdt_timeout;
    end
  end

  // Summary bits and interrupt; a mask hides the request, not the flag
  always_comb begin
    event_summary = {|flags.grp_c, |flags.grp_b};
    irq_n = !(|(flags.grp_a & `PMSC_MASK_A_BITS & ~irq_mask_group_a) ||
              |(flags.grp_b & `PMSC_MASK_B_BITS & ~irq_mask_group_b) ||
              |(flags.grp_c & `PMSC_MASK_C_BITS &
                ~irq_mask_group_c));
  end

  // Settings driven from register bits; reset out and wake block also use low_power_state and trials
  assign domain_targets = power_domain_targets[2:0];
  assign low_power_state_to_partial =
    power_domain_targets[`PMSC_A_STANDBY];
  assign soft_inrush_enable =
    power_behaviour_options[`PMSC_B_SLOWSTART];
  assign key_lock_low_power_state_select =
    power_behaviour_options[`PMSC_B_KEY_LOCK];
  assign system_reset_out_n = !(low_power_state &&
    power_behaviour_options[`PMSC_B_RES_MODE]);
  assign wake_blocked = power_behaviour_options[`PMSC_B_FREEZE_EN] &&
    trials >= power_behaviour_options[`PMSC_B_LIMIT_LSB +: 2];
  assign slot0_default_supplies =
    supply_boot_debounce_config[`PMSC_C_SLOT0_DEFAULT_SUPPLIES];
  assign wake_config_reload_enable =
    supply_boot_debounce_config[`PMSC_C_OTP_WAKE];
  assign auto_boot =
    supply_boot_debounce_config[`PMSC_C_AUTO_BOOT];
  assign ramp_step_cycles_b13 = ramp_cycles(
    supply_boot_debounce_config[`PMSC_C_SLEW_LSB +: 2], 1'b0);
  assign ramp_step_cycles_b2 = ramp_cycles(
    supply_boot_debounce_config[`PMSC_C_SLEW_LSB +: 2], 1'b1);
endmodule
`default_nettype wire

// ### pmsc_regs_props.sv
// Concurrent checks for the mask and system-control register slice.
// Assumes it is bound onto pmsc_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pmsc_regs_props
  import pmsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire pmsc_req_s req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic write_locked,
  input wire pmsc_flags_s flags,
  input wire logic [1:0] event_summary,
  input wire logic irq_n,
  input wire logic power_key_long_press,
  input wire logic low_power_state_request,
  input wire logic low_power_state_to_partial,
  input wire logic [2:0] domain_targets,
  input wire logic low_power_state,
  input wire logic system_reset_out_n,
  input wire logic [9:0] ramp_step_cycles_b13,
  input wire logic [9:0] ramp_step_cycles_b2,
  input wire logic wdt_timeout
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [7:0] sh_a, sh_b, sh_c;
  logic sh_lock, mapped, in_window;
  // Shadows of masks and lock rebuilt from the writes seen at the port
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sh_a <= 8'h00;
      sh_b <= 8'h00;
      sh_c <= 8'h00;
      sh_lock <= 1'b0;
    end else if (req.wr) begin
      if (req.addr == 9'h00A) sh_a <= req.wdata;
      if (req.addr == 9'h00B) sh_b <= req.wdata;
      if (req.addr == 9'h00C) sh_c <= req.wdata;
      if (req.addr == 9'h012) sh_lock <= req.wdata[7];
    end
  end
  // Decodes used by several properties
  assign mapped = req.addr inside {9'h00A, 9'h00B, 9'h00C, 9'h00E,
                                   9'h00F, 9'h010, 9'h011, 9'h012};
  assign in_window = req.addr >= 9'h081 && req.addr <= 9'h120 &&
                     req.addr != 9'h100;
  sequence s_wr_targets;
    req.wr && req.addr == 9'h00E;
  endsequence
  sequence s_rd_mapped;
    req.rd && mapped;
  endsequence
  a_read_hit: assert property (s_rd_mapped |=> reg_hit)
    else $error("mapped read gave no hit");
  a_read_unmapped: assert property (req.rd && !mapped |=>
    !reg_hit && reg_rdata == 8'h00) else $error("unmapped read answered");
  a_target_gate: assert property (s_wr_targets |=> domain_targets ==
    $past((req.wdata[6:4] & req.wdata[2:0]) |
    (~req.wdata[6:4] & domain_targets))) else $error("target gate wrong");
  a_partial_select: assert property (s_wr_targets |=>
    low_power_state_to_partial == $past(req.wdata[3]))
    else $error("partial select not stored");
  a_target_low_power_state: assert property ($fell(domain_targets[0]) |->
    low_power_state_request) else $error("no low_power_state on target clear");
  a_key_low_power_state: assert property (power_key_long_press |=>
    low_power_state_request) else $error("no low_power_state on long press");
  a_reset_out_idle: assert property (!low_power_state |->
    system_reset_out_n) else $error("reset out asserted while awake");
  a_write_lock: assert property (write_locked ==
    (sh_lock && req.wr && in_window)) else $error("write lock wrong");
  a_summary_bits: assert property (event_summary ==
    {|flags.grp_c, |flags.grp_b}) else $error("summary bits wrong");
  a_irq_unmasked: assert property (irq_n ==
    !(|(flags.grp_a & 8'h19 & ~sh_a) | |(flags.grp_b & 8'hAA & ~sh_b) |
    |(flags.grp_c & 8'h1F & ~sh_c))) else $error("interrupt level wrong");
  a_ramp_double: assert property (ramp_step_cycles_b2 ==
    {ramp_step_cycles_b13[8:0], 1'b0}) else $error("buck 2 step not double");
  a_wdt_pulse: assert property (wdt_timeout |=> !wdt_timeout)
    else $error("watchdog pulse too long");
endmodule
bind pmsc_regs pmsc_regs_props u_pmsc_regs_props (.clk_sys, .sys_rst, .req,
  .reg_rdata, .reg_hit, .write_locked, .flags, .event_summary, .irq_n,
  .power_key_long_press, .low_power_state_request, .low_power_state_to_partial,
  .domain_targets, .low_power_state, .system_reset_out_n,
  .ramp_step_cycles_b13, .ramp_step_cycles_b2, .wdt_timeout);
`default_nettype wire

// ### pmsc_host_model.sv
// Host side of the register port: one-cycle read and write strobes.
// Assumes the design takes strobes on the rising edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pmsc_host_model
  import pmsc_pkg::*;
(
  input wire logic clk_sys,
  output var pmsc_req_s req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic write_locked
);
  initial req = '0;
  // Strobe raised off the falling edge so the taking edge sees it settled
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d,
                        output logic lk);
    @(negedge clk_sys);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    lk = write_locked;
    @(negedge clk_sys);
    req = '0;
  endtask
  // Hit stands only one cycle, so read data and hit are taken at the next fall
  task automatic rd_reg(input logic [8:0] a, output logic [7:0] d,
                        output logic h);
    @(negedge clk_sys);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    req = '0;
    d = reg_rdata;
    h = reg_hit;
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the mask and system-control register slice.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmsc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  pmsc_req_s req;
  pmsc_flags_s flags = '0;
  logic [7:0] reg_rdata, rd_d;
  logic reg_hit, write_locked, irq_n, low_power_state_request, rd_h, lk;
  logic low_power_state_to_partial, system_reset_out_n, soft_inrush_enable;
  logic key_lock_low_power_state_select, wake_blocked, slot0_default_supplies;
  logic wake_config_reload_enable, auto_boot, wdt_timeout;
  logic [1:0] event_summary;
  logic [2:0] domain_targets;
  logic [9:0] ramp_step_cycles_b13, ramp_step_cycles_b2;
  logic [6:0] debounced;
  logic power_key_long_press = 1'b0;
  logic low_power_state = 1'b0;
  logic sys_pin = 1'b1;
  logic key_pin = 1'b1;
  logic [4:0] gpi_pins = 5'h00;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  localparam logic [8:0] ADDRS [8] = '{9'h00A, 9'h00B, 9'h00C, 9'h00E,
                                       9'h00F, 9'h010, 9'h011, 9'h012};
  localparam logic [7:0] BITS [8] = '{8'h19, 8'hAA, 8'h1F, 8'h7F,
                                      8'hFE, 8'hFF, 8'h07, 8'h80};
  localparam logic [8:0] LOCK_ADDR [4] = '{9'h081, 9'h100, 9'h120, 9'h121};
  always #5 clk_sys = ~clk_sys;
  // Short tick and watchdog base keep the timed paths within the run
  pmsc_regs #(.TICK_CYCLES(2), .WDT_BASE_TICKS(4)) u_pmsc_regs (
    .clk_sys, .sys_rst, .req, .reg_rdata, .reg_hit, .write_locked, .flags,
    .event_summary, .irq_n, .sys_domain_request_in(sys_pin),
    .power_key_long_press, .low_power_state_request, .low_power_state_to_partial,
    .domain_targets, .low_power_state, .system_reset_out_n,
    .soft_inrush_enable, .key_lock_low_power_state_select, .wake_blocked,
    .slot0_default_supplies, .wake_config_reload_enable, .auto_boot,
    .ramp_step_cycles_b13, .ramp_step_cycles_b2, .gpi_raw(gpi_pins),
    .power_key_n(key_pin), .reset_request_in_n(1'b1), .debounced,
    .wdt_kick(1'b0), .wdt_timeout);
  pmsc_host_model u_pmsc_host_model (.clk_sys, .req, .reg_rdata, .reg_hit,
    .write_locked);
  task automatic chk_val(input string nm, input logic [9:0] e,
                         input logic [9:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_val(nm, {9'h000, e}, {9'h000, g});
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    u_pmsc_host_model.wr_reg(a, d, lk);
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
    u_pmsc_host_model.rd_reg(a, rd_d, rd_h);
    chk_val("rdata", {2'b00, e}, {2'b00, rd_d});
    chk_bit("hit", (a != 9'h00D && a != 9'h013), rd_h);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard well above the expected few hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    foreach (ADDRS[i]) rd_chk(ADDRS[i], 8'h00);
    // Fill every register, exercise the lock window, then clear all but the domain targets, held by zero gate bits
    for (int p = 0; p < 2; p++) begin
      foreach (ADDRS[i]) wr(ADDRS[i], p ? 8'h00 : 8'hFF);
      foreach (ADDRS[i]) rd_chk(ADDRS[i], p ? (i == 3 ? 8'h07 : 8'h00)
                                            : BITS[i]);
      foreach (LOCK_ADDR[k]) begin
        u_pmsc_host_model.wr_reg(LOCK_ADDR[k], 8'h55, lk);
        chk_bit("locked", !p && k[0] == 1'b0, lk);
      end
    end
    rd_chk(9'h00D, 8'h00);
    rd_chk(9'h013, 8'h00);
    wr(9'h00E, 8'h70);
    chk_bit("pd target", 1'b1, low_power_state_request);
    rd_chk(9'h00E, 8'h70);
    wr(9'h00E, 8'h0B);
    rd_chk(9'h00E, 8'h08);
    chk_bit("partial", 1'b1, low_power_state_to_partial);
    wr(9'h00E, 8'h23);
    chk_val("targets", 10'h002, {7'h00, domain_targets});
    @(negedge clk_sys) power_key_long_press = 1'b1;
    @(negedge clk_sys) power_key_long_press = 1'b0;
    chk_bit("pd key", 1'b1, low_power_state_request);
    // Releasing the system pin passes two synchroniser flops first
    sys_pin = 1'b0;
    repeat (2) @(negedge clk_sys)
      chk_bit("pd idle", 1'b0, low_power_state_request);
    @(negedge clk_sys) chk_bit("pd pin", 1'b1, low_power_state_request);
    @(negedge clk_sys);
    chk_bit("pd pulse", 1'b0, low_power_state_request);
    sys_pin = 1'b1;
    // Each flag alone: a set mask hides it, a clear mask passes it only on a writable mask bit
    for (int i = 0; i < 24; i++) begin
      flags = pmsc_flags_s'(24'h000001 << i);
      wr(9'h00C - 9'(i / 8), 8'h01 << (i % 8));
      chk_bit("irq masked", 1'b1, irq_n);
      chk_val("summary", {8'h00, i / 8 == 0, i / 8 == 1},
              {8'h00, event_summary});
      wr(9'h00C - 9'(i / 8), 8'h00);
      chk_bit("irq open", !BITS[2 - i / 8][i % 8], irq_n);
    end
    flags = '0;
    wr(9'h00F, 8'h08);
    low_power_state = 1'b1;
    @(negedge clk_sys);
    chk_bit("rst out", 1'b0, system_reset_out_n);
    wr(9'h00F, 8'h94);
    chk_bit("rst out", 1'b1, system_reset_out_n);
    low_power_state = 1'b0;
    chk_bit("slow start", 1'b1, soft_inrush_enable);
    chk_bit("key lock", 1'b1, key_lock_low_power_state_select);
    chk_bit("blocked", 1'b1, wake_blocked);
    wr(9'h00F, 8'hE4);
    chk_bit("blocked", 1'b0, wake_blocked);
    for (int c = 0; c < 4; c++) begin
      wr(9'h010, 8'(c << 5) | (c[0] ? 8'h98 : 8'h00));
      chk_val("ramp", 10'(400 >> c), ramp_step_cycles_b13);
      chk_val("ramp2", 10'(800 >> c), ramp_step_cycles_b2);
      chk_bit("supplies", c[0], slot0_default_supplies);
      chk_bit("reload", c[0], wake_config_reload_enable);
      chk_bit("boot", c[0], auto_boot);
    end
    // Code 0 leaves only the synchroniser; code 1 waits ten ticks
    gpi_pins = 5'h15;
    key_pin = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk_val("deb sync", 10'h060, {3'h0, debounced});
    @(negedge clk_sys);
    chk_val("deb none", 10'h055, {3'h0, debounced});
    wr(9'h010, 8'hF9);
    gpi_pins = 5'h00;
    key_pin = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk_val("deb hold", 10'h055, {3'h0, debounced});
    repeat (2) @(negedge clk_sys);
    chk_val("deb done", 10'h060, {3'h0, debounced});
    wr(9'h00F, 8'hA4);
    chk_bit("blocked", 1'b0, wake_blocked);
    wr(9'h011, 8'h01);
    cycles = 0;
    while (wdt_timeout !== 1'b1 && cycles < 200) @(negedge clk_sys);
    chk_bit("wdt fired", 1'b1, wdt_timeout);
    // Tick phase lets the first tick fall one clock early
    chk_bit("wdt time", 1'b1, cycles >= 7 && cycles <= 8);
    @(negedge clk_sys) chk_bit("blocked", 1'b1, wake_blocked);
    // Watchdog halts in the low-power state until the option bit is set
    low_power_state = 1'b1;
    repeat (20) @(negedge clk_sys)
      chk_bit("wdt sleep off", 1'b0, wdt_timeout);
    wr(9'h00F, 8'hA6);
    cycles = 0;
    while (wdt_timeout !== 1'b1 && cycles < 20) @(negedge clk_sys);
    chk_bit("wdt sleep on", 1'b1, wdt_timeout);
    low_power_state = 1'b0;
    wr(9'h011, 8'h00);
    repeat (50) @(negedge clk_sys)
      chk_bit("wdt off", 1'b0, wdt_timeout);
    final_report();
  end
endmodule
`default_nettype wire
